/* File: src/lsx_core_map.vh */
`ifndef LSX_CORE_MAP_VH
`define LSX_CORE_MAP_VH

// ****************************************
// reset values and direct page base
// ****************************************
`define LSX_PC_RST 16'h0000
`define LSX_SP_RST 8'hff
`define LSX_REG_RST 8'h00
`define LSX_PG_BASE 8'h00

// ****************************************
// accumulator loads
// ****************************************
`define OP_LDACC_IMM 8'hc4
`define OP_LDACC_PG 8'hc5
`define OP_LDACC_DPX 8'hc6
`define OP_LDACC_ABS 8'hc7
`define OP_LDACC_ABSY 8'hd5
`define OP_LDACC_INDX 8'hd6
`define OP_LDACC_INDY 8'hd7
`define OP_LDACC_IX 8'hd4
`define OP_LDACC_IXP 8'hdb

// ****************************************
// index loads and immediate store
// ****************************************
`define OP_STI_PG 8'he4
`define OP_LDXI_IMM 8'h1e
`define OP_LDXI_PG 8'hcc
`define OP_LDXI_DPY 8'hcd
`define OP_LDXI_ABS 8'hdc
`define OP_LDYI_IMM 8'h3e
`define OP_LDYI_PG 8'hc9
`define OP_LDYI_DPX 8'hd9
`define OP_LDYI_ABS 8'hd8

// ****************************************
// stores
// ****************************************
`define OP_STACC_PG 8'he5
`define OP_STACC_DPX 8'he6
`define OP_STACC_ABS 8'he7
`define OP_STACC_ABSY 8'hf5
`define OP_STACC_INDX 8'hf6
`define OP_STACC_INDY 8'hf7
`define OP_STACC_IX 8'hf4
`define OP_STACC_IXP 8'hfb
`define OP_STXI_PG 8'hec
`define OP_STXI_DPY 8'hed
`define OP_STXI_ABS 8'hfc
`define OP_STYI_PG 8'he9
`define OP_STYI_DPX 8'hf9
`define OP_STYI_ABS 8'hf8

// ****************************************
// transfers and exchanges
// ****************************************
`define OP_ACC2X 8'he8
`define OP_ACC2Y 8'h9f
`define OP_SP2X 8'hae
`define OP_X2ACC 8'hc8
`define OP_X2SP 8'h8e
`define OP_Y2ACC 8'hbf
`define OP_SWAX 8'hee
`define OP_SWAY 8'hde
`define OP_SWMA_PG 8'hbc
`define OP_SWMA_DPX 8'had
`define OP_SWMA_IX 8'hbb
`define OP_SWXY 8'hfe

`endif

/* File: src/lsx_core.v */
`timescale 1ns/10ps
`include "lsx_core_map.vh"

module lsx_core (
    input wire i_clk_sys, // system clock
    input wire i_rst, // synchronous reset, active high
    input wire [7:0] i_prog_data, // program byte at o_prog_addr
    input wire [7:0] i_dmem_rdata, // data byte at o_dmem_addr
    output wire [15:0] o_prog_addr, // program fetch address
    output wire [15:0] o_dmem_addr, // data memory address
    output wire [7:0] o_dmem_wdata, // data memory write byte
    output wire o_dmem_we, // data write strobe
    output wire o_dmem_re, // data read strobe
    output wire [7:0] o_acc, // accumulator
    output wire [7:0] o_idx_x, // first index register
    output wire [7:0] o_idx_y, // second index register
    output wire [7:0] o_sp, // stack pointer
    output wire o_flag_n, // negative flag
    output wire o_flag_z, // zero flag
    output wire o_done, // high for the one cycle after an instruction's last cycle
    output wire o_illegal // opcode outside this group retired
);

    // ****************************************
    // encodings
    // ****************************************
    localparam [2:0] PH_OPC = 3'h0, PH_OP1 = 3'h1, PH_OP2 = 3'h2, PH_PLO = 3'h3;
    localparam [2:0] PH_PHI = 3'h4, PH_RD = 3'h5, PH_WR = 3'h6, PH_WAIT = 3'h7;
    localparam [3:0] M_NONE = 4'h0, M_IMM = 4'h1, M_PG = 4'h2, M_DPX = 4'h3, M_DPY = 4'h4;
    localparam [3:0] M_ABS = 4'h5, M_ABSY = 4'h6, M_INDX = 4'h7, M_INDY = 4'h8;
    localparam [3:0] M_IX = 4'h9, M_IXP = 4'ha, M_DPIMM = 4'hb;
    localparam [4:0] C_LD_ACC = 5'h00, C_LD_XI = 5'h01, C_LD_YI = 5'h02, C_ST_ACC = 5'h03, C_ST_XI = 5'h04;
    localparam [4:0] C_ST_YI = 5'h05, C_STI = 5'h06, C_ACC2X = 5'h07, C_ACC2Y = 5'h08, C_SP2X = 5'h09;
    localparam [4:0] C_X2ACC = 5'h0a, C_X2SP = 5'h0b, C_Y2ACC = 5'h0c, C_SW_AX = 5'h0d, C_SW_AY = 5'h0e;
    localparam [4:0] C_SW_MA = 5'h0f, C_SW_XY = 5'h10, C_ILL = 5'h11;

    // {length, cycles, mode, class}
    function [13:0] dec;
        input [7:0] op;
        begin
            case (op)
                `OP_LDACC_IMM: dec = {2'h2, 3'h2, M_IMM, C_LD_ACC};
                `OP_LDACC_PG: dec = {2'h2, 3'h3, M_PG, C_LD_ACC};
                `OP_LDACC_DPX: dec = {2'h2, 3'h4, M_DPX, C_LD_ACC};
                `OP_LDACC_ABS: dec = {2'h3, 3'h4, M_ABS, C_LD_ACC};
                `OP_LDACC_ABSY: dec = {2'h3, 3'h5, M_ABSY, C_LD_ACC};
                `OP_LDACC_INDX: dec = {2'h2, 3'h6, M_INDX, C_LD_ACC};
                `OP_LDACC_INDY: dec = {2'h2, 3'h6, M_INDY, C_LD_ACC};
                `OP_LDACC_IX: dec = {2'h1, 3'h3, M_IX, C_LD_ACC};
                `OP_LDACC_IXP: dec = {2'h1, 3'h4, M_IXP, C_LD_ACC};
                `OP_STI_PG: dec = {2'h3, 3'h5, M_DPIMM, C_STI};
                `OP_LDXI_IMM: dec = {2'h2, 3'h2, M_IMM, C_LD_XI};
                `OP_LDXI_PG: dec = {2'h2, 3'h3, M_PG, C_LD_XI};
                `OP_LDXI_DPY: dec = {2'h2, 3'h4, M_DPY, C_LD_XI};
                `OP_LDXI_ABS: dec = {2'h3, 3'h4, M_ABS, C_LD_XI};
                `OP_LDYI_IMM: dec = {2'h2, 3'h2, M_IMM, C_LD_YI};
                `OP_LDYI_PG: dec = {2'h2, 3'h3, M_PG, C_LD_YI};
                `OP_LDYI_DPX: dec = {2'h2, 3'h4, M_DPX, C_LD_YI};
                `OP_LDYI_ABS: dec = {2'h3, 3'h4, M_ABS, C_LD_YI};
                `OP_STACC_PG: dec = {2'h2, 3'h4, M_PG, C_ST_ACC};
                `OP_STACC_DPX: dec = {2'h2, 3'h5, M_DPX, C_ST_ACC};
                `OP_STACC_ABS: dec = {2'h3, 3'h5, M_ABS, C_ST_ACC};
                `OP_STACC_ABSY: dec = {2'h3, 3'h6, M_ABSY, C_ST_ACC};
                `OP_STACC_INDX: dec = {2'h2, 3'h7, M_INDX, C_ST_ACC};
                `OP_STACC_INDY: dec = {2'h2, 3'h7, M_INDY, C_ST_ACC};
                `OP_STACC_IX: dec = {2'h1, 3'h4, M_IX, C_ST_ACC};
                `OP_STACC_IXP: dec = {2'h1, 3'h4, M_IXP, C_ST_ACC};
                `OP_STXI_PG: dec = {2'h2, 3'h4, M_PG, C_ST_XI};
                `OP_STXI_DPY: dec = {2'h2, 3'h5, M_DPY, C_ST_XI};
                `OP_STXI_ABS: dec = {2'h3, 3'h5, M_ABS, C_ST_XI};
                `OP_STYI_PG: dec = {2'h2, 3'h4, M_PG, C_ST_YI};
                `OP_STYI_DPX: dec = {2'h2, 3'h5, M_DPX, C_ST_YI};
                `OP_STYI_ABS: dec = {2'h3, 3'h5, M_ABS, C_ST_YI};
                `OP_ACC2X: dec = {2'h1, 3'h2, M_NONE, C_ACC2X};
                `OP_ACC2Y: dec = {2'h1, 3'h2, M_NONE, C_ACC2Y};
                `OP_SP2X: dec = {2'h1, 3'h2, M_NONE, C_SP2X};
                `OP_X2ACC: dec = {2'h1, 3'h2, M_NONE, C_X2ACC};
                `OP_X2SP: dec = {2'h1, 3'h2, M_NONE, C_X2SP};
                `OP_Y2ACC: dec = {2'h1, 3'h2, M_NONE, C_Y2ACC};
                `OP_SWAX: dec = {2'h1, 3'h4, M_NONE, C_SW_AX};
                `OP_SWAY: dec = {2'h1, 3'h4, M_NONE, C_SW_AY};
                `OP_SWMA_PG: dec = {2'h2, 3'h5, M_PG, C_SW_MA};
                `OP_SWMA_DPX: dec = {2'h2, 3'h6, M_DPX, C_SW_MA};
                `OP_SWMA_IX: dec = {2'h1, 3'h5, M_IX, C_SW_MA};
                `OP_SWXY: dec = {2'h1, 3'h4, M_NONE, C_SW_XY};
                default: dec = {2'h1, 3'h2, M_NONE, C_ILL};
            endcase
        end
    endfunction

    // ****************************************
    // state
    // ****************************************
    reg [2:0] ph_ff, nxt_ph;
    reg [2:0] cnt_ff, nxt_cnt;
    reg [7:0] opc_ff, nxt_opc;
    reg [15:0] pc_ff, nxt_pc;
    reg [15:0] dad_ff, nxt_dad;
    reg [7:0] wd_ff, nxt_wd;
    reg we_ff, nxt_we;
    reg re_ff, nxt_re;
    reg [7:0] op1_ff, nxt_op1;
    reg [7:0] plo_ff, nxt_plo;
    reg [7:0] acc_ff, nxt_acc;
    reg [7:0] x_ff, nxt_x;
    reg [7:0] y_ff, nxt_y;
    reg [7:0] sp_ff, nxt_sp;
    reg n_ff, nxt_n;
    reg z_ff, nxt_z;
    reg done_ff, nxt_done;
    reg ill_ff, nxt_ill;

    reg [13:0] dcur;
    reg [1:0] len;
    reg [2:0] cyc;
    reg [3:0] mode;
    reg [4:0] cls;
    reg ld_en, fl_en, is_st;
    reg [7:0] ld_v, fl_v, st_v, sum8;

    // ****************************************
    // sequencer
    // ****************************************
    always @* begin
        // opcode is decoded straight off the bus in its own fetch cycle
        dcur = (ph_ff == PH_OPC) ? dec(i_prog_data) : dec(opc_ff);
        len = dcur[13:12];
        cyc = dcur[11:9];
        mode = dcur[8:5];
        cls = dcur[4:0];
        is_st = (cls == C_ST_ACC) || (cls == C_ST_XI) || (cls == C_ST_YI) || (cls == C_STI);
        st_v = (cls == C_ST_XI) ? x_ff : (cls == C_ST_YI) ? y_ff : acc_ff;
        nxt_ph = ph_ff;
        nxt_cnt = cnt_ff + 3'h1;
        nxt_opc = opc_ff;
        nxt_pc = pc_ff;
        nxt_dad = dad_ff;
        nxt_wd = wd_ff;
        nxt_we = 1'b0;
        nxt_re = 1'b0;
        nxt_op1 = op1_ff;
        nxt_plo = plo_ff;
        nxt_acc = acc_ff;
        nxt_x = x_ff;
        nxt_y = y_ff;
        nxt_sp = sp_ff;
        nxt_n = n_ff;
        nxt_z = z_ff;
        nxt_done = 1'b0;
        nxt_ill = 1'b0;
        ld_en = 1'b0;
        ld_v = i_dmem_rdata;
        fl_en = 1'b0;
        fl_v = 8'h00;
        sum8 = 8'h00;
        case (ph_ff)
            PH_OPC: begin
                nxt_opc = i_prog_data;
                nxt_pc = pc_ff + 16'h0001;
                if (len != 2'h1) begin
                    nxt_ph = PH_OP1;
                end else if (mode == M_IX || mode == M_IXP) begin
                    nxt_dad = {`LSX_PG_BASE, x_ff};
                    nxt_wd = st_v;
                    nxt_we = is_st;
                    nxt_re = !is_st;
                    nxt_ph = is_st ? PH_WR : PH_RD;
                end else begin
                    nxt_ph = PH_WAIT;
                end
            end
            PH_OP1: begin
                nxt_op1 = i_prog_data;
                nxt_pc = pc_ff + 16'h0001;
                sum8 = i_prog_data + ((mode == M_DPY) ? y_ff : x_ff);
                nxt_wd = st_v;
                if (len == 2'h3) begin
                    nxt_ph = PH_OP2;
                end else if (mode == M_IMM) begin
                    ld_en = 1'b1;
                    ld_v = i_prog_data;
                    nxt_ph = PH_WAIT;
                end else if (mode == M_INDX || mode == M_INDY) begin
                    nxt_dad = {`LSX_PG_BASE, (mode == M_INDX) ? sum8 : i_prog_data};
                    nxt_re = 1'b1;
                    nxt_ph = PH_PLO;
                end else begin
                    nxt_dad = {`LSX_PG_BASE, (mode == M_PG) ? i_prog_data : sum8};
                    nxt_we = is_st;
                    nxt_re = !is_st;
                    nxt_ph = is_st ? PH_WR : PH_RD;
                end
            end
            PH_OP2: begin
                nxt_pc = pc_ff + 16'h0001;
                if (mode == M_DPIMM) begin
                    nxt_dad = {`LSX_PG_BASE, op1_ff};
                    nxt_wd = i_prog_data;
                end else begin
                    nxt_dad = {i_prog_data, op1_ff} + ((mode == M_ABSY) ? {8'h00, y_ff} : 16'h0000);
                    nxt_wd = st_v;
                end
                nxt_we = is_st;
                nxt_re = !is_st;
                nxt_ph = is_st ? PH_WR : PH_RD;
            end
            PH_PLO: begin
                // pointer high byte wraps inside the direct page
                nxt_plo = i_dmem_rdata;
                sum8 = dad_ff[7:0] + 8'h01;
                nxt_dad = {dad_ff[15:8], sum8};
                nxt_re = 1'b1;
                nxt_ph = PH_PHI;
            end
            PH_PHI: begin
                nxt_dad = {i_dmem_rdata, plo_ff} + ((mode == M_INDY) ? {8'h00, y_ff} : 16'h0000);
                nxt_wd = st_v;
                nxt_we = is_st;
                nxt_re = !is_st;
                nxt_ph = is_st ? PH_WR : PH_RD;
            end
            PH_RD: begin
                ld_en = 1'b1;
                if (mode == M_IXP) begin
                    nxt_x = x_ff + 8'h01;
                end
                if (cls == C_SW_MA) begin
                    nxt_wd = acc_ff;
                    nxt_we = 1'b1;
                    nxt_ph = PH_WR;
                end else begin
                    nxt_ph = PH_WAIT;
                end
            end
            PH_WR: begin
                if (mode == M_IXP && cls == C_ST_ACC) begin
                    nxt_x = x_ff + 8'h01;
                end
                nxt_ph = PH_WAIT;
            end
            PH_WAIT: begin
                if (cnt_ff == cyc) begin
                    fl_en = 1'b1;
                    case (cls)
                        C_ACC2X: begin nxt_x = acc_ff; fl_v = acc_ff; end
                        C_ACC2Y: begin nxt_y = acc_ff; fl_v = acc_ff; end
                        C_SP2X: begin nxt_x = sp_ff; fl_v = sp_ff; end
                        C_X2ACC: begin nxt_acc = x_ff; fl_v = x_ff; end
                        C_X2SP: begin nxt_sp = x_ff; fl_v = x_ff; end
                        C_Y2ACC: begin nxt_acc = y_ff; fl_v = y_ff; end
                        C_SW_AX: begin nxt_acc = x_ff; nxt_x = acc_ff; fl_en = 1'b0; end
                        C_SW_AY: begin nxt_acc = y_ff; nxt_y = acc_ff; fl_en = 1'b0; end
                        C_SW_XY: begin nxt_x = y_ff; nxt_y = x_ff; fl_en = 1'b0; end
                        C_ILL: begin nxt_ill = 1'b1; fl_en = 1'b0; end
                        default: fl_en = 1'b0;
                    endcase
                end
            end
            default: nxt_ph = PH_OPC;
        endcase
        if (ld_en) begin
            fl_en = 1'b1;
            fl_v = ld_v;
            case (cls)
                C_LD_XI: nxt_x = ld_v;
                C_LD_YI: nxt_y = ld_v;
                default: nxt_acc = ld_v;
            endcase
        end
        if (fl_en) begin
            nxt_n = fl_v[7];
            nxt_z = (fl_v == 8'h00);
        end
        // every instruction is padded out to its full cycle count
        if (nxt_ph == PH_WAIT && cnt_ff == cyc) begin
            nxt_ph = PH_OPC;
        end
        if (nxt_ph == PH_OPC && ph_ff != PH_OPC) begin
            nxt_cnt = 3'h1;
            nxt_done = 1'b1;
        end
    end

    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            ph_ff <= PH_OPC;
            cnt_ff <= 3'h1;
            opc_ff <= 8'h00;
            pc_ff <= `LSX_PC_RST;
            dad_ff <= 16'h0000;
            wd_ff <= 8'h00;
            we_ff <= 1'b0;
            re_ff <= 1'b0;
            op1_ff <= 8'h00;
            plo_ff <= 8'h00;
            acc_ff <= `LSX_REG_RST;
            x_ff <= `LSX_REG_RST;
            y_ff <= `LSX_REG_RST;
            sp_ff <= `LSX_SP_RST;
            n_ff <= 1'b0;
            z_ff <= 1'b0;
            done_ff <= 1'b0;
            ill_ff <= 1'b0;
        end else begin
            ph_ff <= nxt_ph;
            cnt_ff <= nxt_cnt;
            opc_ff <= nxt_opc;
            pc_ff <= nxt_pc;
            dad_ff <= nxt_dad;
            wd_ff <= nxt_wd;
            we_ff <= nxt_we;
            re_ff <= nxt_re;
            op1_ff <= nxt_op1;
            plo_ff <= nxt_plo;
            acc_ff <= nxt_acc;
            x_ff <= nxt_x;
            y_ff <= nxt_y;
            sp_ff <= nxt_sp;
            n_ff <= nxt_n;
            z_ff <= nxt_z;
            done_ff <= nxt_done;
            ill_ff <= nxt_ill;
        end
    end

    assign o_prog_addr = pc_ff;
    assign o_dmem_addr = dad_ff;
    assign o_dmem_wdata = wd_ff;
    assign o_dmem_we = we_ff;
    assign o_dmem_re = re_ff;
    assign o_acc = acc_ff;
    assign o_idx_x = x_ff;
    assign o_idx_y = y_ff;
    assign o_sp = sp_ff;
    assign o_flag_n = n_ff;
    assign o_flag_z = z_ff;
    assign o_done = done_ff;
    assign o_illegal = ill_ff;

endmodule

/* File: dv/lsx_core_chk.sv */
`timescale 1ns/10ps

module lsx_core_chk (
    input wire i_clk_sys, // system clock
    input wire i_rst, // synchronous reset
    input wire [7:0] i_prog_data, // program byte
    input wire [7:0] i_dmem_rdata, // data byte
    input wire [15:0] o_prog_addr, // fetch address
    input wire [15:0] o_dmem_addr, // data address
    input wire [7:0] o_dmem_wdata, // write byte
    input wire o_dmem_we, // write strobe
    input wire o_dmem_re, // read strobe
    input wire [7:0] o_acc, // accumulator
    input wire [7:0] o_idx_x, // first index
    input wire [7:0] o_idx_y, // second index
    input wire [7:0] o_sp, // stack pointer
    input wire o_flag_n, // negative flag
    input wire o_flag_z, // zero flag
    input wire o_done, // instruction boundary
    input wire o_illegal // foreign opcode
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    done_pulse_a: assert property (o_done |=> !o_done)
        else $error("done held longer than one cycle");
    done_gap_a: assert property (o_done |-> ##[2:7] o_done)
        else $error("no instruction boundary within seven cycles");
    first_done_a: assert property ($fell(i_rst) |-> ##[1:8] o_done)
        else $error("first instruction did not finish after reset");
    pc_step_a: assert property ($changed(o_prog_addr) |-> o_prog_addr == $past(o_prog_addr) + 16'h0001)
        else $error("fetch address did not step by one");
    we_pulse_a: assert property (o_dmem_we |=> !o_dmem_we)
        else $error("write strobe longer than one cycle");
    rw_excl_a: assert property (!(o_dmem_we && o_dmem_re))
        else $error("read and write strobes together");
    regs_commit_a: assert property (($changed(o_acc) || $changed(o_sp) || $changed(o_flag_n)
        || $changed(o_flag_z)) |-> (o_done || $past(o_dmem_re)))
        else $error("register or flag changed away from a boundary");
    // a data read commits its byte one edge after the read cycle, at or before the boundary
    x_step_a: assert property (($changed(o_idx_x) && !o_done && !$past(o_dmem_re))
        |-> o_idx_x == $past(o_idx_x) + 8'h01)
        else $error("index changed mid instruction by other than one");
    illegal_done_a: assert property (o_illegal |-> o_done)
        else $error("illegal pulse off a boundary");

    cover property (o_dmem_we);
    cover property (o_illegal);
    cover property (o_done && o_flag_z);
    cover property (o_dmem_re ##1 o_dmem_we);
endmodule

bind lsx_core lsx_core_chk chk_u (.i_clk_sys, .i_rst, .i_prog_data, .i_dmem_rdata, .o_prog_addr, .o_dmem_addr,
    .o_dmem_wdata, .o_dmem_we, .o_dmem_re, .o_acc, .o_idx_x, .o_idx_y, .o_sp, .o_flag_n, .o_flag_z, .o_done,
    .o_illegal);

/* File: dv/lsx_mem_model.sv */
`timescale 1ns/10ps

module lsx_mem_model (
    input wire i_clk_sys, // system clock
    input wire [15:0] i_prog_addr, // fetch address
    output logic [7:0] o_prog_data, // program byte
    input wire [15:0] i_dmem_addr, // data address
    input wire [7:0] i_dmem_wdata, // write byte
    input wire i_dmem_we, // write strobe
    input wire i_dmem_re, // read strobe
    output logic [7:0] o_dmem_rdata // data byte
);
    logic [7:0] prog_mem [0:1023];
    logic [7:0] data_mem [0:65535];
    logic [7:0] last_ff = 8'h00;

    assign o_prog_data = prog_mem[i_prog_addr[9:0]];
    // outside a read the bus shows the inverse of the last byte, so a stray sample is caught
    assign o_dmem_rdata = i_dmem_re ? data_mem[i_dmem_addr] : ~last_ff;

    always @(posedge i_clk_sys) begin
        if (i_dmem_re) begin
            last_ff <= data_mem[i_dmem_addr];
        end
        if (i_dmem_we) begin
            data_mem[i_dmem_addr] <= i_dmem_wdata;
        end
    end
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/10ps

module tb_top;
    typedef struct packed {
        logic [7:0] cyc;
        logic [7:0] a;
        logic [7:0] x;
        logic [7:0] y;
        logic [7:0] sp;
        logic n;
        logic z;
        logic ill;
    } lsx_exp_t;

    logic i_clk_sys;
    logic i_rst;
    wire [7:0] prog_data;
    wire [7:0] dmem_rdata;
    wire [15:0] prog_addr;
    wire [15:0] dmem_addr;
    wire [7:0] dmem_wdata;
    wire dmem_we;
    wire dmem_re;
    wire [7:0] acc;
    wire [7:0] idx_x;
    wire [7:0] idx_y;
    wire [7:0] sp;
    wire flag_n;
    wire flag_z;
    wire done;
    wire illegal;
    int err_count;
    int total_checks;
    int pc;
    logic [7:0] rnd;
    logic [7:0] sa, sx, sy, ssp;
    logic sn, sz;
    logic [7:0] smem [0:65535];
    lsx_exp_t exp_q[$];
    localparam logic [7:0] OPS [0:44] = '{8'hc4, 8'hc5, 8'hc6, 8'hc7, 8'hd5, 8'hd6, 8'hd7, 8'hd4, 8'hdb,
        8'he4, 8'h1e, 8'hcc, 8'hcd, 8'hdc, 8'h3e, 8'hc9, 8'hd9, 8'hd8, 8'he5, 8'he6, 8'he7, 8'hf5, 8'hf6,
        8'hf7, 8'hf4, 8'hfb, 8'hec, 8'hed, 8'hfc, 8'he9, 8'hf9, 8'hf8, 8'he8, 8'h9f, 8'hae, 8'hc8, 8'h8e,
        8'hbf, 8'hee, 8'hde, 8'hbc, 8'had, 8'hbb, 8'hfe, 8'h00};

    lsx_core dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_prog_data(prog_data), .i_dmem_rdata(dmem_rdata),
        .o_prog_addr(prog_addr), .o_dmem_addr(dmem_addr), .o_dmem_wdata(dmem_wdata), .o_dmem_we(dmem_we),
        .o_dmem_re(dmem_re), .o_acc(acc), .o_idx_x(idx_x), .o_idx_y(idx_y), .o_sp(sp), .o_flag_n(flag_n),
        .o_flag_z(flag_z), .o_done(done), .o_illegal(illegal));
    lsx_mem_model mem_u (.i_clk_sys(i_clk_sys), .i_prog_addr(prog_addr), .o_prog_data(prog_data),
        .i_dmem_addr(dmem_addr), .i_dmem_wdata(dmem_wdata), .i_dmem_we(dmem_we), .i_dmem_re(dmem_re),
        .o_dmem_rdata(dmem_rdata));

    initial begin
        i_clk_sys = 1'b0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end

    function automatic logic [7:0] rb();
        rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
        return rnd;
    endfunction

    // ****************************************
    // reference behaviour
    // ****************************************
    // packed as {bytes, cycles}
    function automatic logic [7:0] op_timing(input logic [7:0] op);
        case (op)
            8'hc4, 8'h1e, 8'h3e: return 8'h22;
            8'hc5, 8'hcc, 8'hc9: return 8'h23;
            8'hc6, 8'hcd, 8'hd9, 8'he5, 8'hec, 8'he9: return 8'h24;
            8'hc7, 8'hdc, 8'hd8: return 8'h34;
            8'hd5, 8'he7, 8'hfc, 8'hf8, 8'he4: return 8'h35;
            8'hd6, 8'hd7, 8'had: return 8'h26;
            8'hd4: return 8'h13;
            8'hdb, 8'hfb, 8'hf4, 8'hee, 8'hde, 8'hfe: return 8'h14;
            8'he6, 8'hed, 8'hf9, 8'hbc: return 8'h25;
            8'hf5: return 8'h36;
            8'hf6, 8'hf7: return 8'h27;
            8'hbb: return 8'h15;
            default: return 8'h12;
        endcase
    endfunction

    function automatic logic [15:0] eff_addr(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
        logic [7:0] p;
        p = b1 + sx;
        case (op)
            8'hc5, 8'he5, 8'hcc, 8'hc9, 8'hec, 8'he9, 8'hbc, 8'he4: return {8'h00, b1};
            8'hc6, 8'he6, 8'hd9, 8'hf9, 8'had: return {8'h00, p};
            8'hcd, 8'hed: return {8'h00, b1 + sy};
            8'hc7, 8'he7, 8'hdc, 8'hfc, 8'hd8, 8'hf8: return {b2, b1};
            8'hd5, 8'hf5: return {b2, b1} + {8'h00, sy};
            8'hd6, 8'hf6: return {smem[{8'h00, p + 8'h01}], smem[{8'h00, p}]};
            8'hd7, 8'hf7: return {smem[{8'h00, b1 + 8'h01}], smem[{8'h00, b1}]} + {8'h00, sy};
            default: return {8'h00, sx};
        endcase
    endfunction

    task automatic step_model(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
        logic [15:0] ad;
        logic [7:0] v;
        logic upd;
        ad = eff_addr(op, b1, b2);
        upd = 1'b1;
        case (op)
            8'hc4, 8'h1e, 8'h3e: v = b1;
            8'hc8, 8'h8e: v = sx;
            8'hbf: v = sy;
            8'he8, 8'h9f: v = sa;
            8'hae: v = ssp;
            default: v = smem[ad];
        endcase
        case (op)
            8'hbc, 8'had, 8'hbb: begin
                smem[ad] = sa;
                sa = v;
            end
            8'he8, 8'hae, 8'h1e, 8'hcc, 8'hcd, 8'hdc: sx = v;
            8'h9f, 8'h3e, 8'hc9, 8'hd9, 8'hd8: sy = v;
            8'h8e: ssp = v;
            8'hc4, 8'hc5, 8'hc6, 8'hc7, 8'hd5, 8'hd6, 8'hd7, 8'hd4, 8'hdb, 8'hc8, 8'hbf: sa = v;
            default: upd = 1'b0;
        endcase
        if (upd) begin
            sn = v[7];
            sz = (v == 8'h00);
        end
        case (op)
            8'he4: smem[ad] = b2;
            8'he5, 8'he6, 8'he7, 8'hf5, 8'hf6, 8'hf7, 8'hf4, 8'hfb: smem[ad] = sa;
            8'hec, 8'hed, 8'hfc: smem[ad] = sx;
            8'he9, 8'hf9, 8'hf8: smem[ad] = sy;
            8'hee: {sa, sx} = {sx, sa};
            8'hde: {sa, sy} = {sy, sa};
            8'hfe: {sx, sy} = {sy, sx};
            default: ;
        endcase
        if (op == 8'hdb || op == 8'hfb) begin
            sx = sx + 8'h01;
        end
    endtask

    // ****************************************
    // program assembly, run and compare
    // ****************************************
    task automatic emit(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
        logic [7:0] tm;
        tm = op_timing(op);
        mem_u.prog_mem[pc] = op;
        mem_u.prog_mem[pc + 1] = b1;
        mem_u.prog_mem[pc + 2] = b2;
        pc = pc + tm[7:4];
        step_model(op, b1, b2);
        exp_q.push_back({4'h0, tm[3:0], sa, sx, sy, ssp, sn, sz, op == 8'h00});
    endtask

    task automatic check(input logic [42:0] got, input logic [42:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        int cnt;
        int guard;
        i_rst = 1'b1;
        err_count = 0;
        total_checks = 0;
        rnd = 8'h34;
        {sa, sx, sy, ssp, sn, sz} = {24'h000000, 8'hff, 2'b00};
        pc = 0;
        for (int i = 0; i < 1024; i++) begin
            mem_u.prog_mem[i] = 8'h00;
        end
        for (int i = 0; i < 65536; i++) begin
            smem[i] = i[7:0] ^ i[15:8] ^ 8'h5a;
            mem_u.data_mem[i] = smem[i];
        end
        emit(8'h1e, 8'hff, 8'h00);
        emit(8'hdb, 8'h00, 8'h00);
        emit(8'hfb, 8'h00, 8'h00);
        emit(8'hc4, 8'h00, 8'h00);
        emit(8'he4, 8'h40, 8'h80);
        emit(8'hc4, 8'h80, 8'h00);
        emit(8'he8, 8'h00, 8'h00);
        emit(8'h3e, 8'h00, 8'h00);
        emit(8'hbf, 8'h00, 8'h00);
        emit(8'h8e, 8'h00, 8'h00);
        emit(8'hae, 8'h00, 8'h00);
        emit(8'hd6, 8'h7f, 8'h00);
        emit(8'h3e, 8'hf0, 8'h00);
        emit(8'hf7, 8'h20, 8'h00);
        emit(8'had, 8'hf0, 8'h00);
        emit(8'h00, 8'h00, 8'h00);
        for (int i = 0; i < 45; i++) begin
            emit(OPS[i], rb(), rb());
        end
        for (int i = 0; i < 150; i++) begin
            emit(OPS[rb() % 45], rb(), rb());
        end
        repeat (20) @(posedge i_clk_sys);
        #1;
        check({prog_addr, acc, sp, dmem_we, dmem_re, done, illegal, flag_n, flag_z, 5'h00},
            {16'h0000, 8'h00, 8'hff, 11'h000});
        i_rst = 1'b0;
        cnt = 0;
        guard = 0;
        while (exp_q.size() > 0 && guard < 10) begin
            @(posedge i_clk_sys);
            #1;
            cnt++;
            guard++;
            if (done === 1'b1) begin
                check({cnt[7:0], acc, idx_x, idx_y, sp, flag_n, flag_z, illegal}, exp_q.pop_front());
                cnt = 0;
                guard = 0;
            end
        end
        if (guard >= 10) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, guard, 0);
        end
        for (int i = 0; i < 65536; i++) begin
            check({35'h0, mem_u.data_mem[i]}, {35'h0, smem[i]});
        end
        report_and_stop();
    end
endmodule
